// ===== rtl/efi_defines.svh
// Purpose: offsets, field positions and code constants of the ecc error block
// Assumes: byte addresses on an 8-bit register port, 32-bit register data
// Notes: included by bare name from every design file except the package
`ifndef EFI_DEFINES_SVH
`define EFI_DEFINES_SVH
// ***************************************
// register offsets
// ***************************************
`define EFI_OFS_CFG 8'h00
`define EFI_OFS_STAT 8'h04
`define EFI_OFS_GEN 8'h08
`define EFI_OFS_RGU_CTL 8'h0C
`define EFI_OFS_RGU_STAT 8'h10
`define EFI_OFS_RAM_CAP 8'h20
`define EFI_OFS_FL_CAP 8'h30
`define EFI_CAP_BLK_MASK 8'hF0
// ***************************************
// field positions
// ***************************************
`define EFI_CFG_RAM_NC 0
`define EFI_CFG_FL_NC 1
`define EFI_STAT_RAM_SB 0
`define EFI_STAT_RAM_NC 1
`define EFI_STAT_FL_SB 4
`define EFI_STAT_FL_NC 5
`define EFI_STAT_MASK 8'h33
`define EFI_GEN_RAM_INJ 0
`define EFI_RGU_DIS 0
`define EFI_RGU_SS 1
`define EFI_RGU_FLAG 0
// ***************************************
// code constants
// ***************************************
`define EFI_INJ_FLIP 8'h03
`define EFI_CHK_ERASED 8'hFF
`define EFI_HW0_BASE 7'h30
`define EFI_HW1_BASE 7'h50
`define EFI_HW2_BASE 7'h60
`define EFI_HW3_BASE 7'h70
`define EFI_VAR_NONE 0
`define EFI_VAR_LOCKED 1
`define EFI_VAR_OPEN 2
`endif

// ===== rtl/efi_pkg.sv
// Purpose: shared types of the ecc error block
// Assumes: nothing
// Notes: no imports; used as efi_pkg::name
package efi_pkg;
   // source of the last uncorrectable error
   typedef enum logic [1:0] {
      EFI_SRC_NONE,
      EFI_SRC_RAM,
      EFI_SRC_FLASH
   } efi_src_type;
endpackage

// ===== rtl/efi_secded.sv
// Purpose: 64-bit secded encoder, checker and corrector
// Assumes: 8 checkbits, odd-weight columns
// Notes: every all-ones or all-zeros halfword adds nothing to the check
`timescale 1ns/1ps
`default_nettype none
`include "efi_defines.svh"
module efi_secded (
   input wire logic [63:0] data_in,
   input wire logic [7:0] check_in,
   output logic [7:0] check_out,
   output logic [63:0] data_out,
   output logic single_out,
   output logic multi_out
);
   logic [7:0] acc;
   logic [7:0] syn;

   // column of one data bit: aligned 16-run per halfword, xor of run is zero
   function automatic logic [7:0] efi_col(input int unsigned idx);
      logic [6:0] v;
      case (idx / 16)
         0: v = `EFI_HW0_BASE;
         1: v = `EFI_HW1_BASE;
         2: v = `EFI_HW2_BASE;
         default: v = `EFI_HW3_BASE;
      endcase
      v = v + 7'(idx % 16);
      return {~^v, v};
   endfunction

   // checkbits are the inverted column sum
   always_comb begin
      acc = 8'h00;
      for (int i = 0; i < 64; i++) begin
         if (data_in[i]) begin
            acc = acc ^ efi_col(i);
         end
      end
      check_out = ~acc;
   end

   assign syn = check_out ^ check_in;

   // flip the single data bit whose column matches
   always_comb begin
      data_out = data_in;
      for (int i = 0; i < 64; i++) begin
         if (syn == efi_col(i)) begin
            data_out[i] = ~data_in[i];
         end
      end
   end

   // odd syndrome is correctable, even nonzero is not
   assign single_out = ^syn;
   assign multi_out = (syn != 8'h00) && !(^syn);
endmodule
`default_nettype wire

// ===== rtl/efi_capture.sv
// Purpose: address, master, attribute and data capture of one memory
// Assumes: capture pulse from the error checker on the same clock
// Notes: only the power-on reset clears it
`timescale 1ns/1ps
`default_nettype none
`include "efi_defines.svh"
module efi_capture (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic cap_in,
   input wire logic [31:0] addr_in,
   input wire logic [3:0] master_in,
   input wire logic [7:0] attr_in,
   input wire logic [63:0] data_in,
   input wire logic [1:0] sel_in,
   output logic [31:0] word_out
);
   logic [31:0] addr_r;
   logic [11:0] ma_r;
   logic [63:0] data_r;

   // capture on error, kept through functional reset
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         addr_r <= 32'h0000_0000;
         ma_r <= 12'h000;
         data_r <= 64'h0;
      end else if (cap_in) begin
         addr_r <= addr_in;
         ma_r <= {master_in, attr_in};
         data_r <= data_in;
      end
   end

   // word select: address, master and attribute, data low, data high
   always_comb begin
      case (sel_in)
         2'h0: word_out = addr_r;
         2'h1: word_out = {20'h00000, ma_r};
         2'h2: word_out = data_r[31:0];
         default: word_out = data_r[63:32];
      endcase
   end
endmodule
`default_nettype wire

// ===== rtl/efi_top.sv
// Purpose: ecc error status, injection and safety reset routing
// Assumes: one clock, memories return data and checkbits in the read cycle
// Notes: VARIANT picks plain, locked-reset or configurable-reset behaviour
//
// Overview of operation
// - inject double-bit error into SRAM on request
// - flash multibit detected, not corrected, flagged
// - erased-style halfword patterns encode to all ones
// - safety multibit raises critical faults sixteen, seventeen
// - locked variant: fault flag, reset from phase one
// - enabled reporting plus multibit error resets device
// - capture registers survive functional reset
// - error config register cleared by reset
// - reading invalid capture set gives lockstep error
// - open variant: reset-disable bit is writable
// - disabled reset: safe-mode request and two checks
// - bus error to fault interrupt spacing unfixed
// - status flags clear by writing ones
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "efi_defines.svh"
module efi_top #(
   parameter int VARIANT = `EFI_VAR_OPEN
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic func_rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   input wire logic [31:0] mem_addr_in,
   input wire logic [3:0] mem_master_in,
   input wire logic [7:0] mem_attr_in,
   input wire logic ram_wr_in,
   input wire logic [63:0] ram_wdata_in,
   output logic [7:0] ram_wcheck_out,
   input wire logic ram_rd_in,
   input wire logic [63:0] ram_rdata_in,
   input wire logic [7:0] ram_rcheck_in,
   output logic [63:0] ram_rdata_out,
   output logic ram_bus_err_out,
   input wire logic fl_rd_in,
   input wire logic [63:0] fl_rdata_in,
   input wire logic [7:0] fl_rcheck_in,
   output logic [63:0] fl_rdata_out,
   output logic fl_bus_err_out,
   output logic critical_fault_sixteen_out,
   output logic critical_fault_seventeen_out,
   output logic safe_mode_req_out,
   output logic reset_req_out,
   output logic reset_phase_one_out,
   output logic lockstep_err_out
);
   // ***************************************
   // declarations
   // ***************************************
   logic [1:0] cfg_r;
   logic [7:0] stat_r;
   logic inj_r;
   logic dis_r;
   logic flag_r;
   logic ram_ok_r;
   logic fl_ok_r;
   efi_pkg::efi_src_type src_r;
   logic [7:0] wr_chk;
   logic [63:0] ram_fix;
   logic [63:0] fl_fix;
   logic ram_sb_raw;
   logic ram_mb_raw;
   logic fl_sb_raw;
   logic fl_mb_raw;
   logic ram_sb;
   logic ram_mb;
   logic fl_sb;
   logic fl_mb;
   logic any_mb;
   logic safety;
   logic rep_en;
   logic rst_go;
   logic lockstep_evt;
   logic [7:0] stat_set;
   logic [7:0] stat_clr;
   logic [31:0] ram_word;
   logic [31:0] fl_word;
   logic [31:0] rd_mux;
   logic wr_cfg;
   logic wr_stat;
   logic wr_gen;
   logic wr_rgu;
   logic wr_rgs;
   logic rd_ramcap;
   logic rd_flcap;

   // ***************************************
   // checkers and capture sets
   // ***************************************
   efi_secded u_wr_enc (
      .data_in(ram_wdata_in),
      .check_in(`EFI_CHK_ERASED),
      .check_out(wr_chk),
      .data_out(),
      .single_out(),
      .multi_out()
   );

   efi_secded u_ram_chk (
      .data_in(ram_rdata_in),
      .check_in(ram_rcheck_in),
      .check_out(),
      .data_out(ram_fix),
      .single_out(ram_sb_raw),
      .multi_out(ram_mb_raw)
   );

   efi_secded u_fl_chk (
      .data_in(fl_rdata_in),
      .check_in(fl_rcheck_in),
      .check_out(),
      .data_out(fl_fix),
      .single_out(fl_sb_raw),
      .multi_out(fl_mb_raw)
   );

   efi_capture u_ram_cap (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .cap_in(ram_sb | ram_mb),
      .addr_in(mem_addr_in),
      .master_in(mem_master_in),
      .attr_in(mem_attr_in),
      .data_in(ram_rdata_in),
      .sel_in(reg_addr_in[3:2]),
      .word_out(ram_word)
   );

   efi_capture u_fl_cap (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .cap_in(fl_sb | fl_mb),
      .addr_in(mem_addr_in),
      .master_in(mem_master_in),
      .attr_in(mem_attr_in),
      .data_in(fl_rdata_in),
      .sel_in(reg_addr_in[3:2]),
      .word_out(fl_word)
   );

   // ***************************************
   // decode and events
   // ***************************************
   // register strobes
   assign wr_cfg = reg_wr_in && (reg_addr_in == `EFI_OFS_CFG);
   assign wr_stat = reg_wr_in && (reg_addr_in == `EFI_OFS_STAT);
   assign wr_gen = reg_wr_in && (reg_addr_in == `EFI_OFS_GEN);
   assign wr_rgu = reg_wr_in && (reg_addr_in == `EFI_OFS_RGU_CTL);
   assign wr_rgs = reg_wr_in && (reg_addr_in == `EFI_OFS_RGU_STAT);
   assign rd_ramcap = reg_rd_in && ((reg_addr_in & `EFI_CAP_BLK_MASK) == `EFI_OFS_RAM_CAP);
   assign rd_flcap = reg_rd_in && ((reg_addr_in & `EFI_CAP_BLK_MASK) == `EFI_OFS_FL_CAP);

   // qualified error events
   assign ram_sb = ram_rd_in && ram_sb_raw;
   assign ram_mb = ram_rd_in && ram_mb_raw;
   assign fl_sb = fl_rd_in && fl_sb_raw;
   assign fl_mb = fl_rd_in && fl_mb_raw;
   assign any_mb = ram_mb || fl_mb;
   assign safety = (VARIANT != `EFI_VAR_NONE);
   assign rep_en = |cfg_r;
   assign lockstep_evt = (rd_ramcap && !ram_ok_r) || (rd_flcap && !fl_ok_r);
   // multibit reset unless the open variant has the disable bit set; lockstep error resets always
   assign rst_go = (safety && rep_en && any_mb && !dis_r) || lockstep_evt;

   // status set and clear terms
   always_comb begin
      stat_set = 8'h00;
      stat_set[`EFI_STAT_RAM_SB] = ram_sb;
      stat_set[`EFI_STAT_RAM_NC] = ram_mb;
      stat_set[`EFI_STAT_FL_SB] = fl_sb;
      stat_set[`EFI_STAT_FL_NC] = fl_mb;
      stat_clr = wr_stat ? (reg_wdata_in[7:0] & `EFI_STAT_MASK) : 8'h00;
   end

   // ***************************************
   // registers
   // ***************************************
   // reporting enables, cleared by either reset
   always_ff @(posedge clk_in) begin
      if (srst_in || func_rst_in) begin
         cfg_r <= 2'h0;
      end else if (wr_cfg) begin
         cfg_r <= {reg_wdata_in[`EFI_CFG_FL_NC], reg_wdata_in[`EFI_CFG_RAM_NC]};
      end
   end

   // sticky flags, a new event wins over its clear
   always_ff @(posedge clk_in) begin
      if (srst_in || func_rst_in) begin
         stat_r <= 8'h00;
      end else begin
         stat_r <= stat_set | (stat_r & ~stat_clr);
      end
   end

   // injection arm, consumed by the next ram write
   always_ff @(posedge clk_in) begin
      if (srst_in || func_rst_in) begin
         inj_r <= 1'b0;
      end else if (wr_gen) begin
         inj_r <= reg_wdata_in[`EFI_GEN_RAM_INJ];
      end else if (ram_wr_in) begin
         inj_r <= 1'b0;
      end
   end

   // checkbits for the ram write, two flipped when armed
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         ram_wcheck_out <= `EFI_CHK_ERASED;
      end else if (ram_wr_in) begin
         ram_wcheck_out <= inj_r ? (wr_chk ^ `EFI_INJ_FLIP) : wr_chk;
      end
   end

   // reset-disable bit, writable only on the open variant
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         dis_r <= 1'b0;
      end else if (wr_rgu && (VARIANT == `EFI_VAR_OPEN)) begin
         dis_r <= reg_wdata_in[`EFI_RGU_DIS];
      end
   end

   // reset-cause flag, kept through functional reset
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         flag_r <= 1'b0;
      end else if (safety && rep_en && any_mb) begin
         flag_r <= 1'b1;
      end else if (wr_rgs && reg_wdata_in[`EFI_RGU_FLAG]) begin
         flag_r <= 1'b0;
      end
   end

   // last uncorrectable source and capture validity
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         src_r <= efi_pkg::EFI_SRC_NONE;
         ram_ok_r <= 1'b1;
         fl_ok_r <= 1'b1;
      end else if (func_rst_in) begin
         ram_ok_r <= (src_r != efi_pkg::EFI_SRC_FLASH);
         fl_ok_r <= (src_r != efi_pkg::EFI_SRC_RAM);
      end else if (ram_mb) begin
         src_r <= efi_pkg::EFI_SRC_RAM;
      end else if (fl_mb) begin
         src_r <= efi_pkg::EFI_SRC_FLASH;
      end
   end

   // memory data path, corrected data and bus errors
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         ram_rdata_out <= 64'h0;
         fl_rdata_out <= 64'h0;
         ram_bus_err_out <= 1'b0;
         fl_bus_err_out <= 1'b0;
      end else begin
         ram_rdata_out <= ram_fix;
         fl_rdata_out <= fl_fix;
         ram_bus_err_out <= ram_mb;
         fl_bus_err_out <= fl_mb;
      end
   end

   // fault and reset outputs; fault unit timing is its own clock
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         critical_fault_sixteen_out <= 1'b0;
         critical_fault_seventeen_out <= 1'b0;
         safe_mode_req_out <= 1'b0;
         reset_req_out <= 1'b0;
         reset_phase_one_out <= 1'b0;
         lockstep_err_out <= 1'b0;
      end else begin
         critical_fault_sixteen_out <= safety && any_mb;
         critical_fault_seventeen_out <= safety && any_mb;
         safe_mode_req_out <= safety && rep_en && any_mb && dis_r;
         reset_req_out <= rst_go;
         reset_phase_one_out <= rst_go;
         lockstep_err_out <= lockstep_evt;
      end
   end

   // ***************************************
   // register read
   // ***************************************
   // read mux, unmapped reads zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (rd_ramcap) begin
         rd_mux = ram_word;
      end else if (rd_flcap) begin
         rd_mux = fl_word;
      end else begin
         case (reg_addr_in)
            `EFI_OFS_CFG: rd_mux = {30'h0, cfg_r};
            `EFI_OFS_STAT: rd_mux = {24'h000000, stat_r};
            `EFI_OFS_GEN: rd_mux = {31'h0, inj_r};
            `EFI_OFS_RGU_CTL: rd_mux = {31'h0, dis_r};
            `EFI_OFS_RGU_STAT: rd_mux = {31'h0, flag_r};
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // read data stands one cycle after the strobe only
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else begin
         reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
      end
   end

   // ***************************************
   // checks
   // ***************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   property p_inject_flip;
      ram_wr_in && inj_r |=> ram_wcheck_out == ($past(wr_chk) ^ `EFI_INJ_FLIP);
   endproperty
   a_inject_flip: assert property (p_inject_flip) else $error("inject flip");

   property p_inject_once;
      ram_wr_in && !wr_gen && !func_rst_in
         |=> (!inj_r and (ram_wr_in |=> ram_wcheck_out == $past(wr_chk)));
   endproperty
   a_inject_once: assert property (p_inject_once) else $error("inject reused");

   property p_flash_flag;
      fl_mb && !func_rst_in |=> fl_bus_err_out && stat_r[`EFI_STAT_FL_NC];
   endproperty
   a_flash_flag: assert property (p_flash_flag) else $error("flash multibit lost");

   property p_erased;
      (fl_rdata_in == 64'h0) && (fl_rcheck_in == `EFI_CHK_ERASED) |-> !fl_mb_raw && !fl_sb_raw;
   endproperty
   a_erased: assert property (p_erased) else $error("erased pattern flagged");

   property p_cf;
      safety && any_mb |=> critical_fault_sixteen_out && critical_fault_seventeen_out;
   endproperty
   a_cf: assert property (p_cf) else $error("critical faults missing");

   property p_reset;
      safety && rep_en && any_mb && !dis_r |=> reset_req_out && reset_phase_one_out;
   endproperty
   a_reset: assert property (p_reset) else $error("reset missing");

   property p_cfg_clear;
      func_rst_in |=> (cfg_r == 2'h0) ##1 ((cfg_r == 2'h0) || $past(wr_cfg));
   endproperty
   a_cfg_clear: assert property (p_cfg_clear) else $error("config kept");

   property p_lockstep;
      rd_flcap && !fl_ok_r |=> lockstep_err_out ##0 reset_req_out;
   endproperty
   a_lockstep: assert property (p_lockstep) else $error("lockstep missing");

   property p_safe;
      safety && rep_en && ram_mb && dis_r |=> safe_mode_req_out && ram_bus_err_out && !reset_req_out;
   endproperty
   a_safe: assert property (p_safe) else $error("safe mode missing");

   property p_w1c;
      wr_stat && reg_wdata_in[`EFI_STAT_RAM_NC] && !ram_mb && !func_rst_in
         |=> !stat_r[`EFI_STAT_RAM_NC];
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag not cleared");
endmodule
`default_nettype wire

// ===== testbench/efi_mem_model.sv
// Purpose: behavioural ram and flash arrays facing the ecc block
// Assumes: checkbits of a ram write arrive one cycle after the write
// Notes: flash programming only clears bits, as real cells do
`timescale 1ns/1ps
`default_nettype none
module efi_mem_model (
   input wire logic clk_in,
   input wire logic [1:0] idx_in,
   input wire logic ram_wr_in,
   input wire logic [63:0] ram_wdata_in,
   input wire logic [7:0] ram_wcheck_in,
   input wire logic ram_rd_in,
   output logic [63:0] ram_rdata_out,
   output logic [7:0] ram_rcheck_out,
   input wire logic fl_rd_in,
   output logic [63:0] fl_rdata_out,
   output logic [7:0] fl_rcheck_out
);
   logic [71:0] ram_r [4];
   logic [71:0] fl_r [4];
   logic wr_d_r;
   logic [1:0] wr_idx_r;
   // ***************************************
   // storage
   // ***************************************
   // erased flash, zeroed ram with matching checkbits
   initial begin
      for (int i = 0; i < 4; i++) begin
         ram_r[i] = {8'hFF, 64'h0};
         fl_r[i] = '1;
      end
   end
   // data lands with the write, checkbits one cycle later
   always @(posedge clk_in) begin
      wr_d_r <= ram_wr_in;
      wr_idx_r <= idx_in;
      if (ram_wr_in) begin
         ram_r[idx_in][63:0] <= ram_wdata_in;
      end
      if (wr_d_r) begin
         ram_r[wr_idx_r][71:64] <= ram_wcheck_in;
      end
   end
   // over-programming can only clear bits of data and checkbits
   task automatic fl_program(input logic [1:0] i, input logic [63:0] d, input logic [7:0] c);
      fl_r[i] = fl_r[i] & {c, d};
   endtask
   // ***************************************
   // read side
   // ***************************************
   // lines not being read show the inverse word
   always_comb begin
      {ram_rcheck_out, ram_rdata_out} = ram_rd_in ? ram_r[idx_in] : ~ram_r[idx_in];
      {fl_rcheck_out, fl_rdata_out} = fl_rd_in ? fl_r[idx_in] : ~fl_r[idx_in];
   end
endmodule
`default_nettype wire

// ===== testbench/test_efi_top.sv
// Purpose: register-level tests of the ecc error block
// Assumes: configurable-reset variant, one clock of 8 ns
// Notes: memory contents come from the partner model
`timescale 1ns/1ps
`default_nettype none
`include "efi_defines.svh"
module test_efi_top;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic func_rst_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [31:0] reg_wdata_in = 32'h0;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [31:0] mem_addr_in = 32'h0;
   logic [3:0] mem_master_in = 4'h5;
   logic [7:0] mem_attr_in = 8'hA5;
   logic ram_wr_in = 1'b0;
   logic [63:0] ram_wdata_in = 64'h0;
   logic ram_rd_in = 1'b0;
   logic fl_rd_in = 1'b0;
   logic [31:0] reg_rdata_out;
   logic [7:0] ram_wcheck_out, ram_rcheck, fl_rcheck;
   logic [63:0] ram_rdata, fl_rdata, ram_rdata_out, fl_rdata_out;
   logic ram_bus_err_out, fl_bus_err_out, critical_fault_sixteen, critical_fault_seventeen, safe_mode_req_out;
   logic reset_req_out, reset_phase_one_out, lockstep_err_out, lock_r;
   int miscompares = 0;
   int n_checks = 0;
   logic [63:0] pats [5] = '{64'h0, 64'hFFFF_FFFF_0000_0000, 64'hFFFF_0000_FFFF_0000,
                             64'h0000_FFFF_0000_FFFF, 64'hFFFF_FFFF_FFFF_FFFF};
   always #4 clk_in = ~clk_in;
   // ***************************************
   // design and partner
   // ***************************************
   efi_top #(.VARIANT(2)) u_dut (.clk_in(clk_in), .srst_in(srst_in),
      .func_rst_in(func_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .mem_addr_in(mem_addr_in), .mem_master_in(mem_master_in), .mem_attr_in(mem_attr_in),
      .ram_wr_in(ram_wr_in), .ram_wdata_in(ram_wdata_in), .ram_wcheck_out(ram_wcheck_out),
      .ram_rd_in(ram_rd_in), .ram_rdata_in(ram_rdata), .ram_rcheck_in(ram_rcheck),
      .ram_rdata_out(ram_rdata_out), .ram_bus_err_out(ram_bus_err_out),
      .fl_rd_in(fl_rd_in), .fl_rdata_in(fl_rdata), .fl_rcheck_in(fl_rcheck),
      .fl_rdata_out(fl_rdata_out), .fl_bus_err_out(fl_bus_err_out),
      .critical_fault_sixteen_out(critical_fault_sixteen), .critical_fault_seventeen_out(critical_fault_seventeen),
      .safe_mode_req_out(safe_mode_req_out), .reset_req_out(reset_req_out),
      .reset_phase_one_out(reset_phase_one_out), .lockstep_err_out(lockstep_err_out));
   efi_mem_model u_mem (.clk_in(clk_in), .idx_in(mem_addr_in[4:3]), .ram_wr_in(ram_wr_in),
      .ram_wdata_in(ram_wdata_in), .ram_wcheck_in(ram_wcheck_out), .ram_rd_in(ram_rd_in),
      .ram_rdata_out(ram_rdata), .ram_rcheck_out(ram_rcheck), .fl_rd_in(fl_rd_in),
      .fl_rdata_out(fl_rdata), .fl_rcheck_out(fl_rcheck));
   // ***************************************
   // tasks
   // ***************************************
   // compare and count
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      n_checks++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask
   // one-cycle register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask
   // one-cycle register read, data checked in the following cycle
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1;
      lock_r = lockstep_err_out;
      chk(nm, {32'h0, e}, {32'h0, reg_rdata_out});
   endtask
   // ram doubleword write, checkbits compared one cycle later
   task automatic rw(input logic [1:0] i, input logic [63:0] d, input logic [7:0] ec);
      @(posedge clk_in);
      mem_addr_in <= {27'h0800000, i, 3'h0};
      ram_wdata_in <= d;
      ram_wr_in <= 1'b1;
      @(posedge clk_in);
      ram_wr_in <= 1'b0;
      #1;
      chk("ram_wcheck", {56'h0, ec}, {56'h0, ram_wcheck_out});
   endtask
   // memory read; event pulses {bus_err, critical_fault_sixteen, critical_fault_seventeen, reset, reset_phase_one, safe}
   task automatic mr(input logic fl, input logic [1:0] i, input logic [5:0] ev);
      @(posedge clk_in);
      mem_addr_in <= {27'h0800000, i, 3'h0};
      fl_rd_in <= fl;
      ram_rd_in <= !fl;
      @(posedge clk_in);
      fl_rd_in <= 1'b0;
      ram_rd_in <= 1'b0;
      #1;
      chk("events", {58'h0, ev}, {58'h0, fl ? fl_bus_err_out : ram_bus_err_out, critical_fault_sixteen, critical_fault_seventeen,
          reset_req_out, reset_phase_one_out, safe_mode_req_out});
   endtask
   // verdict
   task automatic end_of_test;
      if (miscompares == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ***************************************
   // tests
   // ***************************************
   initial begin
      repeat (3) @(posedge clk_in);
      srst_in <= 1'b0;
      chk("wcheck_rst", 64'hFF, {56'h0, ram_wcheck_out});
      rd(`EFI_OFS_CFG, 32'h0, "cfg_rst");
      rd(8'h40, 32'h0, "unmapped");
      foreach (pats[k]) rw(2'd1, pats[k], 8'hFF);
      wr(`EFI_OFS_CFG, 32'h1);
      rd(`EFI_OFS_CFG, 32'h1, "cfg_set");
      wr(`EFI_OFS_GEN, 32'h1);
      rw(2'd0, 64'h0, 8'hFC);
      rw(2'd2, 64'h0, 8'hFF);
      rd(`EFI_OFS_GEN, 32'h0, "gen");
      mr(1'b0, 2'd2, 6'b000000);
      chk("ram_data", 64'h0, ram_rdata_out);
      mr(1'b0, 2'd0, 6'b111110);
      rd(`EFI_OFS_STAT, 32'h2, "stat_ram");
      rd(`EFI_OFS_RAM_CAP, 32'h1000_0000, "ram_addr");
      rd(`EFI_OFS_RAM_CAP + 8'h04, 32'h5A5, "ram_attr");
      wr(`EFI_OFS_STAT, 32'h33);
      rd(`EFI_OFS_STAT, 32'h0, "stat_clr");
      @(posedge clk_in);
      func_rst_in <= 1'b1;
      @(posedge clk_in);
      func_rst_in <= 1'b0;
      rd(`EFI_OFS_CFG, 32'h0, "cfg_func");
      rd(`EFI_OFS_RAM_CAP, 32'h1000_0000, "ram_keep");
      chk("lock_ram", 64'h0, {63'h0, lock_r});
      rd(`EFI_OFS_FL_CAP, 32'h0, "fl_addr");
      chk("lock_fl", 64'h1, {63'h0, lock_r});
      wr(`EFI_OFS_RGU_STAT, 32'h1);
      rd(`EFI_OFS_RGU_STAT, 32'h0, "rgu_clr");
      wr(`EFI_OFS_CFG, 32'h2);
      u_mem.fl_program(2'd1, 64'h0, 8'hFF);
      mr(1'b1, 2'd1, 6'b000000);
      u_mem.fl_program(2'd3, 64'hFFFF_FFFF_FFFF_FFFE, 8'hFF);
      mr(1'b1, 2'd3, 6'b000000);
      chk("fl_fix", 64'hFFFF_FFFF_FFFF_FFFF, fl_rdata_out);
      u_mem.fl_program(2'd2, 64'h0, 8'hFF);
      u_mem.fl_program(2'd2, 64'h0, 8'hFC);
      mr(1'b1, 2'd2, 6'b111110);
      rd(`EFI_OFS_STAT, 32'h30, "stat_fl");
      rd(`EFI_OFS_RGU_STAT, 32'h1, "rgu_flag");
      wr(`EFI_OFS_RGU_CTL, 32'h1);
      rd(`EFI_OFS_RGU_CTL, 32'h1, "rgu_ctl");
      mr(1'b1, 2'd2, 6'b111001);
      mr(1'b0, 2'd0, 6'b111001);
      end_of_test();
   end
   // hang guard, far beyond the roughly 75 cycles of the tests
   initial begin
      repeat (5000) @(posedge clk_in);
      miscompares++;
      end_of_test();
   end
endmodule
`default_nettype wire
